/* File: sdram_cfg_pkg.sv */
// Package with configuration bit positions, widths and grouped signal types.
package sdram_cfg_pkg;
   localparam int CCR_W = 32;
   localparam int BCR_W = 32;
   // Controller configuration bit positions, counted from the most significant bit as bit 0.
   localparam int CCR_BANK_RANGE_BIT = 8;
   localparam int CCR_CS_TO_4_BIT = 11;
   localparam int CCR_CS_TO_8_BIT = 12;
   localparam int CCR_UNUSED_BIT = 13;
   localparam int CCR_DQM_STROBE1_BIT = 14;
   localparam int CCR_DQM_ARB_BIT = 15;
   localparam int CCR_RD_EXTRA_BIT = 16;
   localparam int CCR_MUX_SHIFT_BIT = 19;
   localparam int CCR_WR_HOLD_BIT = 21;
   localparam int CCR_CMD_SHIFT_BIT = 22;
   // Organization field of a bank configuration entry, bits 26 to 29.
   localparam int BCR_ORG_MSB = 26;
   localparam int BCR_ORG_LSB = 29;
   localparam int ORG_W = 4;
   localparam logic [CCR_W-1:0] CCR_RESET = 32'h0000_0000;
   localparam int NUM_BANKS = 6;
   localparam int NUM_CS = 12;
   localparam int CS_GROUP = 4;
   localparam int ADDR_W = 14;
   localparam int SDRAM_MHZ_LOW = 100;
   localparam int SDRAM_MHZ_HIGH = 133;
   // Bank size limits in MB.
   localparam int BANK_MIN_MB = 4;
   localparam int BANK_MAX_SMALL_MB = 1024;
   localparam int BANK_MAX_LARGE_MB = 4096;

   // Command-side signals that the delay option shifts together; strobes are active low.
   typedef struct packed {
      logic mux_a2_clken_n;
      logic mux_oe_n;
      logic ras0_n;
      logic ras1_n;
      logic cas0_n;
      logic cas1_n;
      logic we0_n;
      logic we1_n;
      logic addr0_odd;
      logic addr0_even;
      logic [ADDR_W-1:1] addr;
      logic bs0;
      logic bs1;
   } cmd_sig_t;

   // Multiplexer steering signals.
   typedef struct packed {
      logic sel;
      logic clken_b1_n;
      logic clken_b2_n;
   } mux_sig_t;
endpackage : sdram_cfg_pkg

/* File: sdram_interleave_config.sv */
// Configuration, signal-timing and pin re-mapping logic of the interleaved SDRAM controller.
module sdram_interleave_config #(
   parameter int SDRAM_MHZ = sdram_cfg_pkg::SDRAM_MHZ_HIGH,
   parameter int DATA_W = 72
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Configuration load from software
   input wire logic cfg_we,
   input wire logic [sdram_cfg_pkg::CCR_W-1:0] cfg_wdata,
   input wire logic bank_we,
   input wire logic [2:0] bank_idx,
   input wire logic [sdram_cfg_pkg::BCR_W-1:0] bank_wdata,
   // Configuration readback
   output logic [sdram_cfg_pkg::CCR_W-1:0] controller_config_reg,
   output logic [sdram_cfg_pkg::ORG_W-1:0] bank_org [sdram_cfg_pkg::NUM_BANKS],
   output logic [12:0] bank_max_mb_div4,
   output logic bank_write_refused,
   // Internal sequencer side
   input wire sdram_cfg_pkg::cmd_sig_t cmd_in,
   input wire sdram_cfg_pkg::mux_sig_t mux_in,
   input wire logic [sdram_cfg_pkg::NUM_CS/3-1:0] cs_n_in,
   input wire logic dqm_in,
   input wire logic rd_phase_in,
   input wire logic wr_valid_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   // Memory pins
   output sdram_cfg_pkg::cmd_sig_t cmd_out,
   output logic mem_addr_bit_thirteen,
   output sdram_cfg_pkg::mux_sig_t mux_out,
   output logic [sdram_cfg_pkg::NUM_CS-1:0] sdram_chip_select_n,
   output logic wide_pci_arbiter_pin,
   input wire logic arb_func_in,
   output logic rd_phase_out,
   output logic wr_valid_out,
   output logic [DATA_W-1:0] wr_data_out
);
   import sdram_cfg_pkg::*;

   // Refused at elaboration, so a bad build never reaches simulation.
   if (SDRAM_MHZ != SDRAM_MHZ_LOW && SDRAM_MHZ != SDRAM_MHZ_HIGH) begin : g_bad_mhz
      $error("SDRAM clock must be 100 or 133 MHz");
   end
   if (DATA_W < 1) begin : g_bad_data_w
      $error("Write data path needs at least one bit");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers. Bit n of the word counts from the top, as software numbers it.

   logic [CCR_W-1:0] ccr_q;
   logic [ORG_W-1:0] org_q [NUM_BANKS];

   function automatic logic ccr_bit(input logic [CCR_W-1:0] r, input int n);
      return r[CCR_W-1-n];
   endfunction : ccr_bit

   always_ff @(posedge mclk) begin
      if (rst) begin
         ccr_q <= CCR_RESET;
      end else if (cfg_we) begin
         ccr_q <= cfg_wdata;
      end
   end

   // Entries six and seven do not exist, so writes there are refused.
   assign bank_write_refused = bank_we && (bank_idx >= 3'(NUM_BANKS));

   generate
      for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
         always_ff @(posedge mclk) begin
            if (rst) begin
               org_q[b] <= '0;
            end else if (bank_we && bank_idx == 3'(b)) begin
               org_q[b] <= bank_wdata[BCR_W-1-BCR_ORG_MSB -: ORG_W];
            end
         end
         assign bank_org[b] = org_q[b];
      end
   endgenerate

   assign controller_config_reg = ccr_q;

   logic range_small, cs_to4, cs_to8, dqm_strobe1, dqm_arb, rd_extra, mux_shift, wr_hold;
   logic cmd_shift;
   assign range_small = ccr_bit(ccr_q, CCR_BANK_RANGE_BIT);
   assign cs_to4 = ccr_bit(ccr_q, CCR_CS_TO_4_BIT);
   assign cs_to8 = ccr_bit(ccr_q, CCR_CS_TO_8_BIT);
   assign dqm_strobe1 = ccr_bit(ccr_q, CCR_DQM_STROBE1_BIT);
   assign dqm_arb = ccr_bit(ccr_q, CCR_DQM_ARB_BIT);
   assign rd_extra = ccr_bit(ccr_q, CCR_RD_EXTRA_BIT);
   assign mux_shift = ccr_bit(ccr_q, CCR_MUX_SHIFT_BIT);
   assign wr_hold = ccr_bit(ccr_q, CCR_WR_HOLD_BIT);
   assign cmd_shift = ccr_bit(ccr_q, CCR_CMD_SHIFT_BIT);
   // Bit 13 is stored for readback only and steers nothing.

   // Largest allowed bank size in 4MB units.
   assign bank_max_mb_div4 = range_small ? 13'(BANK_MAX_SMALL_MB / BANK_MIN_MB)
                                         : 13'(BANK_MAX_LARGE_MB / BANK_MIN_MB);

   ////////////////////////////////////////////////////////////////////////////
   // One-cycle delay stages for registered DIMMs.

   cmd_sig_t cmd_q;
   mux_sig_t mux_q;
   logic rd_q;
   logic wr_valid_q;
   logic [DATA_W-1:0] wr_data_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_q <= '1;
         cmd_q.addr <= '0;
         cmd_q.addr0_odd <= 1'b0;
         cmd_q.addr0_even <= 1'b0;
         cmd_q.bs0 <= 1'b0;
         cmd_q.bs1 <= 1'b0;
      end else begin
         cmd_q <= cmd_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mux_q <= '{sel: 1'b0, clken_b1_n: 1'b1, clken_b2_n: 1'b1};
      end else begin
         mux_q <= mux_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_q <= 1'b0;
         wr_valid_q <= 1'b0;
         wr_data_q <= '0;
      end else begin
         rd_q <= rd_phase_in;
         wr_valid_q <= wr_valid_in;
         if (wr_valid_in) begin
            wr_data_q <= wr_data_in;
         end
      end
   end

   cmd_sig_t cmd_sel;
   always_comb begin
      cmd_sel = cmd_shift ? cmd_q : cmd_in;
      // The data mask borrows the second strobe set; bank pairs then share strobe set zero.
      if (dqm_strobe1) begin
         cmd_sel.ras1_n = dqm_in;
         cmd_sel.cas1_n = dqm_in;
         cmd_sel.we1_n = dqm_in;
      end
   end
   assign cmd_out = cmd_sel;
   assign mem_addr_bit_thirteen = cmd_sel.addr[ADDR_W-1];

   assign mux_out = mux_shift ? mux_q : mux_in;

   // Reads stretch the sequencer phase by one cycle.
   assign rd_phase_out = rd_phase_in | (rd_extra & rd_q);

   // Write data holds one more cycle; a new beat in that cycle wins over the held one.
   assign wr_valid_out = wr_valid_in | (wr_hold & wr_valid_q);
   assign wr_data_out = wr_valid_in ? wr_data_in : wr_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Chip select fan-out. Only twelve selects exist; copying splits the load on each.

   generate
      for (genvar c = 0; c < CS_GROUP; c++) begin : g_cs
         assign sdram_chip_select_n[c] = cs_n_in[c];
         assign sdram_chip_select_n[c+CS_GROUP] = cs_to4 ? cs_n_in[c] : 1'b1;
         assign sdram_chip_select_n[c+2*CS_GROUP] = cs_to8 ? cs_n_in[c] : 1'b1;
      end
   endgenerate

   assign wide_pci_arbiter_pin = dqm_arb ? dqm_in : arb_func_in;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_cmd_shift_one: assert property (@(posedge mclk) disable iff (rst)
      cmd_shift && $stable(cmd_shift) |-> cmd_out.ras0_n == $past(cmd_in.ras0_n))
      else $error("command strobe not delayed");
   a_cmd_pass_direct: assert property (@(posedge mclk) disable iff (rst)
      !cmd_shift && !dqm_strobe1 |-> cmd_out == cmd_in)
      else $error("command path not direct");
   a_mux_shift_one: assert property (@(posedge mclk) disable iff (rst)
      mux_shift && $stable(mux_shift) |-> mux_out == $past(mux_in))
      else $error("mux select not delayed");
   a_wr_hold_extra: assert property (@(posedge mclk) disable iff (rst)
      wr_hold && wr_valid_in ##1 wr_hold |-> wr_valid_out)
      else $error("write data not held");
   a_rd_extend_one: assert property (@(posedge mclk) disable iff (rst)
      rd_extra && rd_phase_in ##1 rd_extra |-> rd_phase_out)
      else $error("read not extended");
   a_cs_copy_four: assert property (@(posedge mclk) disable iff (rst)
      cs_to4 |-> sdram_chip_select_n[7:4] == cs_n_in)
      else $error("chip selects not copied to 4..7");
   a_cs_copy_eight: assert property (@(posedge mclk) disable iff (rst)
      sdram_chip_select_n[11:8] == (cs_to8 ? cs_n_in : 4'hF))
      else $error("chip selects 8..11 active while off");
   a_dqm_arb_pin: assert property (@(posedge mclk) disable iff (rst)
      dqm_arb |-> wide_pci_arbiter_pin == dqm_in)
      else $error("data mask missing on arbiter pin");
   a_dqm_strobe_pins: assert property (@(posedge mclk) disable iff (rst)
      dqm_strobe1 |-> cmd_out.we1_n == dqm_in && cmd_out.cas1_n == dqm_in &&
      cmd_out.ras1_n == dqm_in)
      else $error("data mask missing on strobe pins");
   a_reset_clears: assert property (@(posedge mclk)
      rst |=> controller_config_reg == CCR_RESET)
      else $error("configuration not cleared by reset");
   a_range_select: assert property (@(posedge mclk) disable iff (rst)
      range_small |-> bank_max_mb_div4 == 13'h100)
      else $error("bank range wrong");

   c_cmd_shift: cover property (@(posedge mclk) cmd_shift && !cmd_in.ras0_n);
   c_wr_hold: cover property (@(posedge mclk) wr_hold && wr_valid_q && !wr_valid_in);
   c_cs_both: cover property (@(posedge mclk) cs_to4 && cs_to8 && !cs_n_in[0]);
   c_bank_refused: cover property (@(posedge mclk) bank_write_refused);
endmodule : sdram_interleave_config

/* File: dimm_pair_model.sv */
// Far-side model of the two interleaved DIMMs, counting write commands seen at the pins.
module dimm_pair_model (
   // Clock
   input wire logic mclk,
   // Memory pins
   input wire sdram_cfg_pkg::cmd_sig_t cmd,
   input wire logic [11:0] cs_n,
   input wire logic wr_valid,
   // Observed traffic
   output logic [7:0] n_writes
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdram_cfg_pkg::*;
   initial n_writes = 8'h00;
   // A write needs a selected chip and valid data on the same edge, else the DIMM drops it.
   always @(posedge mclk) begin
      if (cmd.ras0_n && !cmd.cas0_n && !cmd.we0_n && !(&cs_n) && wr_valid) begin
         n_writes <= n_writes + 8'h01;
      end
   end
endmodule : dimm_pair_model

/* File: tb_top.sv */
// Self-checking bench for the interleave configuration block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sdram_cfg_pkg::*;
   localparam cmd_sig_t IDLE = 25'h1FE0000;
   localparam cmd_sig_t CA = 25'h0155555;
   logic mclk = 1'h0, rst = 1'h1, cfg_we = 1'h0, bank_we = 1'h0, dqm_in = 1'h0;
   logic rd_phase_in = 1'h0, wr_valid_in = 1'h0, arb_func_in = 1'h1;
   logic [31:0] cfg_wdata = 32'h0, bank_wdata = 32'h0;
   logic [2:0] bank_idx = 3'h0;
   logic [3:0] cs_n_in = 4'hF;
   logic [71:0] wr_data_in = 72'h0;
   cmd_sig_t cmd_in = IDLE;
   mux_sig_t mux_in = 3'h5;
   logic bank_write_refused, wide_pci_arbiter_pin, mem_addr_bit_thirteen;
   logic rd_phase_out, wr_valid_out;
   logic [31:0] controller_config_reg;
   logic [3:0] bank_org [NUM_BANKS];
   logic [12:0] bank_max_mb_div4;
   logic [11:0] sdram_chip_select_n;
   logic [71:0] wr_data_out;
   logic [7:0] n_writes;
   cmd_sig_t cmd_out;
   mux_sig_t mux_out;
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   sdram_interleave_config sdram_interleave_config_i (.mclk, .rst, .cfg_we, .cfg_wdata,
      .bank_we, .bank_idx, .bank_wdata, .controller_config_reg, .bank_org, .bank_max_mb_div4,
      .bank_write_refused, .cmd_in, .mux_in, .cs_n_in, .dqm_in, .rd_phase_in, .wr_valid_in,
      .wr_data_in, .cmd_out, .mem_addr_bit_thirteen, .mux_out, .sdram_chip_select_n,
      .wide_pci_arbiter_pin, .arb_func_in, .rd_phase_out, .wr_valid_out, .wr_data_out);
   dimm_pair_model dimm_pair_model_i (.mclk, .cmd(cmd_out), .cs_n(sdram_chip_select_n),
      .wr_valid(wr_valid_out), .n_writes);

   initial begin
      forever #2 mclk = ~mclk;
   end
   // The ceiling is over fifty times the length of the whole sequence.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] cbit(input int n);
      return 32'h0000_0001 << (31 - n);
   endfunction : cbit
   // Loads a configuration word and returns at the negedge where its effect must show.
   task automatic cfg(input logic [31:0] w);
      @(posedge mclk);
      cfg_we <= 1'h1;
      cfg_wdata <= w;
      @(posedge mclk);
      cfg_we <= 1'h0;
      @(negedge mclk);
   endtask : cfg
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(posedge mclk);
      cs_n_in <= 4'hA;
      @(negedge mclk);
      check("config", controller_config_reg, 32'h0);
      check("cs pins", sdram_chip_select_n, 12'hFFA);
      check("arb pin", wide_pci_arbiter_pin, 1'h1);
      check("cmd live", cmd_out, IDLE);
      check("bank max", bank_max_mb_div4, 13'h0400);
   endtask : t_reset
   task automatic t_shift;
      cfg(cbit(CCR_CMD_SHIFT_BIT));
      @(posedge mclk);
      cmd_in <= CA;
      @(posedge mclk);
      cmd_in <= 25'h0AAAAAA;
      @(negedge mclk);
      check("cmd delayed", cmd_out, CA);
      check("addr13", mem_addr_bit_thirteen, CA.addr[13]);
      check("mux live", mux_out, 3'h5);
      cfg(cbit(CCR_MUX_SHIFT_BIT));
      @(posedge mclk);
      mux_in <= 3'h2;
      @(posedge mclk);
      mux_in <= 3'h5;
      @(negedge mclk);
      check("mux delayed", mux_out, 3'h2);
      check("cmd live", cmd_out, 25'h0AAAAAA);
   endtask : t_shift
   task automatic t_rd_wr;
      cfg(cbit(CCR_RD_EXTRA_BIT) | cbit(CCR_WR_HOLD_BIT));
      @(posedge mclk);
      rd_phase_in <= 1'h1;
      wr_valid_in <= 1'h1;
      wr_data_in <= 72'h12_3456_789A_BCDE_F012;
      cmd_in <= 25'h1EA0000;
      cs_n_in <= 4'hE;
      @(posedge mclk);
      rd_phase_in <= 1'h0;
      wr_valid_in <= 1'h0;
      wr_data_in <= 72'h0;
      cmd_in <= IDLE;
      @(negedge mclk);
      check("rd extended", rd_phase_out, 1'h1);
      check("wr held", wr_valid_out, 1'h1);
      check("wr data", wr_data_out, 72'h12_3456_789A_BCDE_F012);
      check("writes", n_writes, 8'h01);
      @(negedge mclk);
      check("rd ends", rd_phase_out, 1'h0);
      check("wr ends", wr_valid_out, 1'h0);
   endtask : t_rd_wr
   task automatic t_pins;
      @(posedge mclk);
      cs_n_in <= 4'h5;
      cfg(cbit(CCR_UNUSED_BIT));
      check("config rd", controller_config_reg, cbit(CCR_UNUSED_BIT));
      check("cs unused", sdram_chip_select_n, 12'hFF5);
      check("arb unused", wide_pci_arbiter_pin, 1'h1);
      cfg(cbit(CCR_CS_TO_4_BIT));
      check("cs to 4", sdram_chip_select_n, 12'hF55);
      cfg(cbit(CCR_CS_TO_8_BIT) | cbit(CCR_DQM_STROBE1_BIT) | cbit(CCR_DQM_ARB_BIT));
      check("cs to 8", sdram_chip_select_n, 12'h5F5);
      check("arb dqm", wide_pci_arbiter_pin, 1'h0);
      check("strobe1 dqm", {cmd_out.ras1_n, cmd_out.cas1_n, cmd_out.we1_n}, 3'h0);
      // Both mask and arbiter input flip, so a pin stuck on either source shows.
      @(posedge mclk);
      dqm_in <= 1'h1;
      arb_func_in <= 1'h0;
      @(negedge mclk);
      check("arb dqm hi", wide_pci_arbiter_pin, 1'h1);
      check("strobe1 dqm hi", {cmd_out.ras1_n, cmd_out.cas1_n, cmd_out.we1_n}, 3'h7);
      check("strobe0 kept", {cmd_out.ras0_n, cmd_out.cas0_n, cmd_out.we0_n}, 3'h7);
   endtask : t_pins
   task automatic t_bank;
      cfg(cbit(CCR_BANK_RANGE_BIT));
      check("bank max", bank_max_mb_div4, 13'h0100);
      @(posedge mclk);
      bank_we <= 1'h1;
      bank_idx <= 3'h5;
      bank_wdata <= 32'h0000_002C;
      @(posedge mclk);
      bank_idx <= 3'h6;
      bank_wdata <= 32'h0000_0014;
      @(negedge mclk);
      check("org", bank_org[5], 4'hB);
      check("refused", bank_write_refused, 1'h1);
      @(posedge mclk);
      bank_we <= 1'h0;
      @(negedge mclk);
      check("refused off", bank_write_refused, 1'h0);
      check("org kept", bank_org[5], 4'hB);
      @(posedge mclk);
      rst <= 1'h1;
      @(posedge mclk);
      rst <= 1'h0;
      @(negedge mclk);
      check("config rst", controller_config_reg, 32'h0);
      check("org rst", bank_org[5], 4'h0);
      check("bank max rst", bank_max_mb_div4, 13'h0400);
   endtask : t_bank
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      t_reset();
      t_shift();
      t_rd_wr();
      t_pins();
      t_bank();
      report_and_stop();
   end
endmodule : tb_top
